// *** hdl/pot_wiper_map.svh ***
// constants of the serial command port: timing, codes, field positions
// assumes an 8 ns system clock; included by the serial link and command port files
`ifndef POT_WIPER_MAP_SVH
`define POT_WIPER_MAP_SVH

// ======================================
// timing
`define CLK_PERIOD_NS 8
`define POR_LOAD_NS 5000
`define POR_LOAD_CYC (`POR_LOAD_NS / `CLK_PERIOD_NS)
`define NV_BUSY_MS 20
`define NV_BUSY_CYC (`NV_BUSY_MS * 1000000 / `CLK_PERIOD_NS)

// ======================================
// values and codes
`define NV_FACTORY 8'h80
`define CMD_WR_WIPER 8'h00
`define CMD_WR_NV 8'h10
`define CMD_CP_W2NV 8'h20
`define CMD_CP_NV2W 8'h30
`define CMD_RD_NV 8'h28
`define CMD_RD_WIPER 8'h68
`define LEN_SHORT 6'h08
`define LEN_LONG 6'h10
`define RD_START 2'h2

// ======================================
// field positions in the 16-bit frame
`define COMMAND_MSB 15
`define COMMAND_LSB 8
`define DATA_BYTE_MSB 7
`define DATA_BYTE_LSB 0

`endif

// *** hdl/pot_types_pkg.sv ***
// types shared by the serial command port files
// assumes nothing beyond the map header
package pot_types_pkg;

  // ======================================
  // core phases
  typedef enum logic {PH_POWER_UP, PH_RUN} phase_t;

  // read-out request handed to the link side
  typedef struct packed {
    logic arm;
    logic [7:0] value;
  } link_rd_t;

  // link side, serial input half
  typedef struct packed {
    logic [15:0] shift;
    logic [5:0] cnt;
    logic [5:0] gray;
  } link_in_t;

  // link side, read-out half
  typedef struct packed {
    logic [1:0] rise_cnt;
    logic [7:0] sh;
    logic drive;
  } link_out_t;

  // system clock side
  typedef struct packed {
    phase_t phase;
    logic [2:0] sel_sync;
    logic [2:0][5:0] gray_sync;
    logic sel_hi;
    logic [5:0] gray_hold;
    logic [5:0] prev_cnt;
    logic [7:0] wiper;
    logic [7:0] nv;
    logic [7:0] nv_pend;
    logic busy;
    logic [21:0] busy_cnt;
    link_rd_t rd;
  } core_t;

endpackage : pot_types_pkg

// *** hdl/pot_serial_link.sv ***
// serial clock side of the command port: bit capture and read-out
// assumes the host keeps select and data stable around serial clock rises
`timescale 1ns/1ns
`include "pot_wiper_map.svh"

module pot_serial_link (
  input wire logic sclk_in,
  input wire logic rst_in,
  input wire logic select_low_in,
  input wire logic sdio_in,
  input pot_types_pkg::link_rd_t rd_in,
  output pot_types_pkg::link_in_t link_out,
  output logic sdio_out,
  output logic sdio_oe_out
);
  import pot_types_pkg::*;

  link_in_t in_st;
  link_in_t in_nx;
  link_out_t out_st;
  link_out_t out_nx;

  function automatic logic [5:0] to_gray(input logic [5:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  // ======================================
  // next state
  always_comb begin
    in_nx = in_st;
    out_nx = out_st;
    if (!select_low_in) begin
      // msb first, first byte ends up in the upper half
      in_nx.shift = {in_st.shift[14:0], sdio_in};
      in_nx.cnt = in_st.cnt + 6'h01;
      in_nx.gray = to_gray(in_nx.cnt);
    end
    if (out_st.rise_cnt != `RD_START) begin
      out_nx.rise_cnt = out_st.rise_cnt + 2'h1;
      if (out_st.rise_cnt == 2'h1) begin
        // second rise after select goes high starts the data
        out_nx.drive = rd_in.arm;
        out_nx.sh = rd_in.value;
      end
    end else begin
      out_nx.sh = {out_st.sh[6:0], 1'b0};
    end
  end

  // ======================================
  // registers
  // input half is frozen while select is high
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      in_st <= '0;
    end else begin
      in_st <= in_nx;
    end
  end

  // held clear while select is low: pin stays an input
  // reset clears it too, else the enable is unknown until the first frame
  always_ff @(posedge sclk_in or posedge rst_in or negedge select_low_in) begin
    if (rst_in || !select_low_in) begin
      out_st <= '0;
    end else begin
      out_st <= out_nx;
    end
  end

  assign link_out = in_st;
  assign sdio_out = out_st.sh[7];
  assign sdio_oe_out = out_st.drive;

  // ======================================
  // checks
  sequence s_second_rise;
    select_low_in && out_st.rise_cnt == 2'h1;
  endsequence

  a_input_phase: assert property (@(posedge sclk_in) disable iff (rst_in)
    !select_low_in |-> !sdio_oe_out)
    else $error("data pin driven while select is low");

  a_read_start: assert property (@(posedge sclk_in) disable iff (rst_in)
    s_second_rise |=> sdio_oe_out == $past(rd_in.arm)
      && sdio_out == $past(rd_in.value[7]))
    else $error("read-out did not start on second rise");

  a_no_early: assert property (@(posedge sclk_in) disable iff (rst_in)
    out_st.rise_cnt != `RD_START |-> !sdio_oe_out)
    else $error("data pin driven before second rise");

  a_shift_in: assert property (@(posedge sclk_in) disable iff (rst_in)
    !select_low_in |=> in_st.shift[0] == $past(sdio_in)
      && in_st.cnt == $past(in_st.cnt) + 6'h01)
    else $error("serial bit not captured");

  a_shift_out: assert property (@(posedge sclk_in) disable iff (rst_in)
    select_low_in && out_st.rise_cnt == `RD_START ##1 select_low_in
      |-> out_st.sh == {$past(out_st.sh[6:0]), 1'b0})
    else $error("read-out not msb first");

endmodule : pot_serial_link

// *** hdl/pot_wiper_serial_command_port.sv ***
// wiper and non-volatile register logic behind a 3-wire serial port
// assumes the host follows the serial timing; sclk_in is the link clock
//
// How it works
// - power-up copies stored value into wiper quickly
// - copy and read take 8 or 16
// - six command codes decoded from first byte
// - command first, each byte msb first
// - wiper value is tap index, zero at low
// - stored write leaves wiper untouched
// - copy wiper value into stored register
// - no automatic save at power-down
// - copy stored value into wiper
// - data pin is input while selected
// - read stored value out after select rises
// - read wiper value out, wiper unchanged
// - output starts on second clock rise
// - select fall releases the data pin
// - stored register starts at mid-scale
// - bits sampled on clock rise while selected
// - command runs on select rise
// - bit count other than 8/16 modulo 64 does nothing
// - stored writes take up to 20 ms
`timescale 1ns/1ns
`include "pot_wiper_map.svh"

module pot_wiper_serial_command_port #(
  parameter int NV_BUSY_CYCLES = `NV_BUSY_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic select_low_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_out,
  output logic [7:0] wiper_tap_out,
  output logic nv_busy_out
);
  import pot_types_pkg::*;

  localparam int POR_MAX = `POR_LOAD_CYC;
  localparam logic [21:0] BUSY_LAST = 22'(NV_BUSY_CYCLES - 1);

  core_t st;
  core_t nx;
  link_in_t link_in;

  logic [5:0] cur_cnt;
  logic [5:0] len;
  logic frame_end;
  logic len_ok;
  logic exec;
  logic [7:0] cmd;
  logic [7:0] data;

  function automatic logic [5:0] from_gray(input logic [5:0] g);
    logic [5:0] b;
    b = g;
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    from_gray = b;
  endfunction : from_gray

  // ======================================
  // link side
  pot_serial_link u_link (
    .sclk_in(sclk_in),
    .rst_in(rst_in),
    .select_low_in(select_low_in),
    .sdio_in(sdio_in),
    .rd_in(st.rd),
    .link_out(link_in),
    .sdio_out(sdio_out),
    .sdio_oe_out(sdio_oe_out)
  );

  // ======================================
  // next state
  always_comb begin
    nx = st;
    frame_end = 1'b0;
    cmd = 8'h00;
    data = 8'h00;

    // three-stage crossings, a change counts once stages two and three agree
    nx.sel_sync = {st.sel_sync[1:0], select_low_in};
    nx.gray_sync = {st.gray_sync[1:0], link_in.gray};
    if (st.gray_sync[1] == st.gray_sync[2]) begin
      nx.gray_hold = st.gray_sync[2];
    end
    cur_cnt = from_gray(nx.gray_hold);
    len = cur_cnt - st.prev_cnt;

    if (st.sel_sync[1] == st.sel_sync[2]) begin
      nx.sel_hi = st.sel_sync[2];
      frame_end = st.sel_sync[2] & ~st.sel_hi;
      if (!st.sel_sync[2] && st.sel_hi) begin
        nx.rd.arm = 1'b0;
      end
    end

    // one byte: command only; two bytes: command then data
    if (len == `LEN_SHORT) begin
      cmd = link_in.shift[`DATA_BYTE_MSB:`DATA_BYTE_LSB];
    end else begin
      cmd = link_in.shift[`COMMAND_MSB:`COMMAND_LSB];
      data = link_in.shift[`DATA_BYTE_MSB:`DATA_BYTE_LSB];
    end
    len_ok = (len == `LEN_SHORT) || (len == `LEN_LONG);
    exec = frame_end && len_ok && st.phase == PH_RUN;

    if (frame_end) begin
      nx.prev_cnt = cur_cnt;
    end

    // stored write runs for the busy time, then commits
    if (st.busy) begin
      if (st.busy_cnt == BUSY_LAST) begin
        nx.busy = 1'b0;
        nx.busy_cnt = 22'h000000;
        nx.nv = st.nv_pend;
      end else begin
        nx.busy_cnt = st.busy_cnt + 22'h000001;
      end
    end

    case (st.phase)
      PH_POWER_UP: begin
        nx.wiper = st.nv;
        nx.phase = PH_RUN;
      end
      PH_RUN: begin
        if (exec) begin
          case (cmd)
            `CMD_WR_WIPER: begin
              // writes need the data byte
              if (len == `LEN_LONG) begin
                nx.wiper = data;
              end
            end
            `CMD_WR_NV: begin
              // a second store while busy is dropped
              if (len == `LEN_LONG && !st.busy) begin
                nx.nv_pend = data;
                nx.busy = 1'b1;
                nx.busy_cnt = 22'h000000;
              end
            end
            `CMD_CP_W2NV: begin
              if (!st.busy) begin
                nx.nv_pend = st.wiper;
                nx.busy = 1'b1;
                nx.busy_cnt = 22'h000000;
              end
            end
            `CMD_CP_NV2W: begin
              nx.wiper = st.nv;
            end
            `CMD_RD_NV: begin
              nx.rd.arm = 1'b1;
              nx.rd.value = st.nv;
            end
            `CMD_RD_WIPER: begin
              nx.rd.arm = 1'b1;
              nx.rd.value = st.wiper;
            end
            default: begin
              nx.rd.arm = 1'b0;
            end
          endcase
        end
      end
      default: begin
        nx.phase = PH_POWER_UP;
      end
    endcase
  end

  // ======================================
  // registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
      st.phase <= PH_POWER_UP;
      st.sel_sync <= 3'h7;
      st.sel_hi <= 1'b1;
      st.nv <= `NV_FACTORY;
      st.nv_pend <= `NV_FACTORY;
    end else begin
      st <= nx;
    end
  end

  assign wiper_tap_out = st.wiper;
  assign nv_busy_out = st.busy;

  // ======================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_exec(logic [7:0] c);
    exec && cmd == c;
  endsequence

  sequence s_idle_store;
    !st.busy;
  endsequence

  a_por_load: assert property (
    $fell(rst_in) |-> ##[0:POR_MAX] (st.phase == PH_RUN && st.wiper == st.nv))
    else $error("power-up load not done in time");

  a_factory_mid: assert property (
    $fell(rst_in) |-> st.nv == `NV_FACTORY)
    else $error("stored value not mid-scale after reset");

  a_write_wiper: assert property (
    s_exec(`CMD_WR_WIPER) and (len == `LEN_LONG) |=> st.wiper == $past(data))
    else $error("wiper write lost");

  a_wnv_keeps_wiper: assert property (
    s_exec(`CMD_WR_NV) and s_idle_store |=> $stable(st.wiper)
      && st.busy && st.nv_pend == $past(data))
    else $error("stored write touched the wiper");

  a_copy_to_nv: assert property (
    s_exec(`CMD_CP_W2NV) and s_idle_store |=> st.busy
      && st.nv_pend == $past(st.wiper))
    else $error("wiper copy not started");

  a_no_autosave: assert property (
    $changed(st.nv) |-> $past(st.busy) && $past(st.busy_cnt) == BUSY_LAST)
    else $error("stored value changed without a store");

  a_copy_to_wiper: assert property (
    s_exec(`CMD_CP_NV2W) |=> st.wiper == $past(st.nv))
    else $error("stored copy not loaded");

  a_read_nv: assert property (
    s_exec(`CMD_RD_NV) |=> st.rd.arm && st.rd.value == $past(st.nv))
    else $error("stored read not armed");

  a_read_wiper: assert property (
    s_exec(`CMD_RD_WIPER) |=> st.rd.arm && st.rd.value == $past(st.wiper)
      && $stable(st.wiper))
    else $error("wiper read not armed");

  a_bad_length: assert property (
    frame_end && !len_ok |=> $stable(st.wiper) && $stable(st.nv_pend)
      && !st.rd.arm)
    else $error("command ran on a bad bit count");

  a_unknown_cmd: assert property (
    exec && cmd != `CMD_WR_WIPER && cmd != `CMD_WR_NV && cmd != `CMD_CP_W2NV
      && cmd != `CMD_CP_NV2W && cmd != `CMD_RD_NV && cmd != `CMD_RD_WIPER
      |=> $stable(st.wiper) && $stable(st.nv_pend) && !st.rd.arm)
    else $error("unknown command changed state");

  a_busy_bound: assert property (
    st.busy |-> st.busy_cnt <= BUSY_LAST)
    else $error("store busy count overran");

  sequence s_busy_end;
    st.busy && st.busy_cnt == BUSY_LAST;
  endsequence

  a_busy_commit: assert property (
    s_busy_end |=> !st.busy && st.nv == $past(st.nv_pend))
    else $error("stored write did not commit");

  a_short_write: assert property (
    s_exec(`CMD_WR_WIPER) and (len == `LEN_SHORT) |=> $stable(st.wiper))
    else $error("wiper write ran without its data byte");

  a_short_store: assert property (
    s_exec(`CMD_WR_NV) and (len == `LEN_SHORT) |=> $stable(st.nv_pend))
    else $error("stored write ran without its data byte");

  sequence s_sel_fall;
    st.sel_sync[1] == st.sel_sync[2] && !st.sel_sync[2] && st.sel_hi;
  endsequence

  a_read_release: assert property (
    s_sel_fall |=> !st.rd.arm)
    else $error("read stayed armed after select fell");

  a_copy_keeps_wiper: assert property (
    s_exec(`CMD_CP_W2NV) |=> $stable(st.wiper))
    else $error("copy to stored moved the wiper");

  a_run_stays: assert property (
    st.phase == PH_RUN |=> st.phase == PH_RUN)
    else $error("power-up load ran twice");

  a_exec_on_rise: assert property (
    exec |-> st.sel_sync[2] && st.sel_sync[1] && !st.sel_hi)
    else $error("command ran while select was low");

endmodule : pot_wiper_serial_command_port

// *** tb/pot_host.sv ***
// host model of the 3-wire link: select, serial clock, data line
// assumes the device drives sdio_out only while sdio_oe_in is high
`timescale 1ns/1ns

module pot_host (
  input wire logic sdio_out_in,
  input wire logic sdio_oe_in,
  output logic sclk_out,
  output logic select_low_out,
  output logic sdio_wire_out
);
  logic drv_reg;
  // undriven line shows the inverse of the last bit, never a held value
  assign sdio_wire_out = sdio_oe_in ? sdio_out_in : drv_reg;
  initial begin
    sclk_out = 1'b0;
    select_low_out = 1'b1;
    drv_reg = 1'b0;
  end
  // ======================================
  // clock pulse, 125 ns; clock stands still outside frames and read-outs
  task automatic pulse();
    #62 sclk_out <= 1'b1;
    #63 sclk_out <= 1'b0;
  endtask : pulse
  // ======================================
  // command frame of n bits, msb first; then gap for execution
  task automatic frame(input logic [15:0] w, input int n);
    // non-blocking: a select edge on a system clock edge must not race its sampler
    select_low_out <= 1'b0;
    #50;
    for (int i = 0; i < n; i++) begin
      drv_reg <= w[15 - i];
      pulse();
    end
    drv_reg <= ~drv_reg;
    #50 select_low_out <= 1'b1;
    #300;
  endtask : frame
  // read-out: oe after rise 1, after last bit, after select falls
  task automatic readout(output logic [7:0] v, output logic [2:0] oe);
    v = 8'h00;
    pulse();
    oe[2] = sdio_oe_in;
    for (int i = 0; i < 8; i++) begin
      pulse();
      v = {v[6:0], sdio_wire_out};
    end
    oe[1] = sdio_oe_in; // select held high up to here
    select_low_out <= 1'b0;
    #20 oe[0] = sdio_oe_in;
    select_low_out <= 1'b1;
    #300;
  endtask : readout
endmodule : pot_host

// *** tb/pot_wiper_serial_command_port_tb.sv ***
// self-checking bench of the serial command port
// assumes the host model in pot_host.sv; busy time shortened to 200 cycles
`timescale 1ns/1ns

module pot_wiper_serial_command_port_tb;
  logic clk_in, rst_in, sclk, sel_low, sdio_w, sdio_out, sdio_oe, nv_busy;
  logic [7:0] wiper_tap, w_exp, nv_exp, rnd, v, cmd, d;
  logic [7:0] codes [8] = '{8'h00, 8'h00, 8'h30, 8'h40, 8'h01, 8'hff, 8'h00, 8'h80};
  logic [2:0] oe;
  int fails, checked, n;

  pot_wiper_serial_command_port #(.NV_BUSY_CYCLES(200)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .select_low_in(sel_low),
    .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe_out(sdio_oe),
    .wiper_tap_out(wiper_tap), .nv_busy_out(nv_busy));
  pot_host host_u (.sdio_out_in(sdio_out), .sdio_oe_in(sdio_oe), .sclk_out(sclk),
    .select_low_out(sel_low), .sdio_wire_out(sdio_w));

  // ======================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // only exact 8 or 16 bit frames run; writes need 16
  function logic [7:0] wiper_after(input logic [7:0] c, input logic [7:0] x, input int k);
    if (c == 8'h00 && k == 16) return x;
    if (c == 8'h30 && (k == 8 || k == 16)) return nv_exp;
    return w_exp;
  endfunction : wiper_after
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input int k, input logic [7:0] exp);
    host_u.frame({c, rnd}, k);
    host_u.readout(v, oe);
    chk(v, exp, "read data");
    chk({5'h00, oe}, 8'h02, "read enable");
  endtask : rd
  task automatic wait_idle();
    for (int k = 0; k < 400 && nv_busy !== 1'b0; k++) @(posedge clk_in);
    chk({7'h00, nv_busy}, 8'h00, "busy end");
  endtask : wait_idle
  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #400000;
    fails++;
    test_done();
  end

  // ======================================
  // main sequence
  initial begin
    rst_in = 1'b1;
    rnd = 8'h34;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    w_exp = 8'h80;
    nv_exp = 8'h80;
    chk(wiper_tap, w_exp, "power-up load");
    rd(8'h28, 8, nv_exp);
    $display("test power-up done");
    foreach (codes[i]) begin
      rnd = lfsr(rnd);
      d = lfsr(rnd);
      n = rnd[3] ? 16 : (rnd[4] ? 8 : 12);
      cmd = codes[rnd[7:5]];
      w_exp = wiper_after(cmd, d, n);
      host_u.frame({cmd, d}, n);
      chk(wiper_tap, w_exp, "random frame");
    end
    host_u.frame({8'h00, 8'h3c}, 8);
    chk(wiper_tap, w_exp, "short write");
    $display("test random frames done");
    for (int i = 0; i < 2; i++) begin
      w_exp = i[0] ? 8'hff : 8'h00;
      host_u.frame({8'h00, w_exp}, 16);
      chk(wiper_tap, w_exp, "end tap");
      rd(8'h68, 8 + 8 * i, w_exp);
      chk(wiper_tap, w_exp, "wiper after read");
    end
    $display("test ends and reads done");
    rnd = lfsr(rnd);
    host_u.frame({8'h10, rnd}, 16);
    chk({7'h00, nv_busy}, 8'h01, "busy start");
    chk(wiper_tap, w_exp, "stored write");
    wait_idle();
    nv_exp = rnd;
    rd(8'h28, 16, nv_exp);
    host_u.frame({8'h30, 8'h00}, 8);
    w_exp = nv_exp;
    chk(wiper_tap, w_exp, "copy to wiper");
    rnd = lfsr(rnd);
    host_u.frame({8'h00, rnd}, 16);
    host_u.frame({8'h20, 8'ha5}, 16);
    wait_idle();
    nv_exp = rnd;
    rd(8'h28, 8, nv_exp);
    $display("test stored register done");
    test_done();
  end
endmodule : pot_wiper_serial_command_port_tb
